//--- hw/lis_core.v
// Operation
// - 32-bit down-counter, mode chosen by entry bit 17.
// - One-shot: load, count down, interrupt at zero unmasked.
// - Periodic: reload at zero, interrupt every zero.
// - Live count loaded from start value register.
// - Divider code selects core clock divide factor.
// - Local input messages raise interrupts unless masked.
// - Trigger bit picks edge or level, fixed only.
// - Level inputs: remote pending blocks until end-of-interrupt.
// - Counter overflow interrupts through its entry unless masked.
// - Thermal event interrupts through its entry unless masked.
// - Feature register reports four extended entries.
// - Each extended source picks its entry by selection.
// - Detected errors raise error-entry interrupt unless masked.
// - Error status write copies and clears accumulated errors.
// - Bits 2, 3 flag unaccepted sent/received messages.
// - Bits 5, 6 flag sent/received illegal vectors.
// - Bit 7 flags access to unimplemented window location.
// - Priority race at acknowledge delivers spurious vector.
// - Disabled: refuse fixed, lowest and external types, local input entries excepted.
// - Disabled: all masks forced set, clears ignored.
// - Bit 9 set disables lowest-priority focus checking.
// - Mask bit 16 set blocks the source.
// - Timer mode 1 periodic, 0 one-shot.
// - Fixed vector below 16 is illegal, flagged.
// - Message type field encodes fixed, lowest, SYSTEM_MANAGEMENT_INTERRUPT, NMI, external.
//
// The Wishbone register port was decided locally.
`include "lis_regs.vh"
module lis_core (
   input wire core_clk,
   input wire reset,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [1:0] localInput,
   input wire [1:0] endOfInterrupt,
   input wire perfOverflow,
   input wire thermalEvent,
   input wire [3:0] extSource,
   input wire [7:0] extSelect,
   input wire sentUnaccepted,
   input wire receivedUnaccepted,
   input wire receivedBadVector,
   input wire [7:0] taskPriority,
   output reg intReq,
   output reg [7:0] intVector,
   output reg [2:0] intType,
   input wire intAck,
   output reg ackValid,
   output reg [7:0] ackVector,
   output reg ackSpurious,
   output reg inServiceSet,
   output reg focusCheckDisable,
   output reg softwareEnable
);

localparam SRC_TIMER = 0;
localparam SRC_THERMAL = 1;
localparam SRC_PERF = 2;
localparam SRC_LOCAL0 = 3;
localparam SRC_ERROR = 5;
localparam SRC_EXT0 = 6;
localparam NSRC = 10;
localparam ST_IDLE = 2'b01;
localparam ST_OFFER = 2'b10;

////////////////////////////////////////////////////////////////////////////////

function [3:0] entryIndex;
   input [11:0] a;
   begin
      case (a)
         `LIS_OFF_TIMER_ENTRY: entryIndex = 4'h0;
         `LIS_OFF_THERMAL_ENTRY: entryIndex = 4'h1;
         `LIS_OFF_PERF_ENTRY: entryIndex = 4'h2;
         `LIS_OFF_LOCAL0_ENTRY: entryIndex = 4'h3;
         `LIS_OFF_LOCAL1_ENTRY: entryIndex = 4'h4;
         `LIS_OFF_ERROR_ENTRY: entryIndex = 4'h5;
         `LIS_OFF_EXT0_ENTRY: entryIndex = 4'h6;
         `LIS_OFF_EXT1_ENTRY: entryIndex = 4'h7;
         `LIS_OFF_EXT2_ENTRY: entryIndex = 4'h8;
         `LIS_OFF_EXT3_ENTRY: entryIndex = 4'h9;
         default: entryIndex = 4'hf;
      endcase
   end
endfunction

// Mask of prescaler bits that must all be set for one tick.
function [6:0] divMask;
   input [3:0] d;
   begin
      case ({d[3], d[1:0]})
         3'b000: divMask = 7'h01;
         3'b001: divMask = 7'h03;
         3'b010: divMask = 7'h07;
         3'b011: divMask = 7'h0f;
         3'b100: divMask = 7'h1f;
         3'b101: divMask = 7'h3f;
         3'b110: divMask = 7'h7f;
         default: divMask = 7'h00;
      endcase
   end
endfunction

function [31:0] mergeSel;
   input [31:0] old;
   input [31:0] din;
   input [3:0] sel;
   integer b;
   begin
      mergeSel = old;
      for (b = 0; b < 4; b = b + 1) begin
         if (sel[b]) begin
            mergeSel[b*8 +: 8] = din[b*8 +: 8];
         end
      end
   end
endfunction

// Types that software enable gates off.
function gatedType;
   input [2:0] t;
   begin
      gatedType = (t == `LIS_MT_FIXED) | (t == `LIS_MT_LOWEST) | (t == `LIS_MT_EXTERNAL_INTERRUPT);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg [17:0] entry [0:NSRC-1];
reg [7:0] spuriousVector;
reg [31:0] startValue;
reg [31:0] liveValue;
reg [3:0] divCode;
reg timerRun;
reg [6:0] divCnt;
reg [7:0] errAccum;
reg [7:0] errStatus;
reg [NSRC-1:0] pending;
reg [1:0] remotePend;
reg [1:0] localPrev;
reg [1:0] state;
reg [3:0] chosen;

wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = access & wb_we_i;
wire [11:0] adr = {wb_adr_i[11:2], 2'b00};
wire [3:0] idx = entryIndex(adr);
wire [6:0] dm = divMask(divCode);
wire tick = ((divCnt & dm) == dm);
wire timerFire = timerRun & tick & (liveValue == 32'h00000001);

reg [31:0] rdData;
reg mapped;
reg [NSRC-1:0] rawEvt;
reg [NSRC-1:0] eligible;
reg [NSRC-1:0] next_pending;
reg [3:0] pick;
reg found;
reg [7:0] errNew;
reg [2:0] pickType;
integer i;
integer j;
integer k;
integer m;

wire [31:0] wdat = mergeSel(rdData, wb_dat_i, wb_sel_i);
wire pickBad = (state == ST_IDLE) & found & (pickType == `LIS_MT_FIXED) &
   (entry[pick][7:0] < `LIS_VEC_MIN);
wire badAccess = access & ~mapped;

////////////////////////////////////////////////////////////////////////////////

always @* begin
   rdData = 32'h00000000;
   mapped = 1'b1;
   if (idx != 4'hf) begin
      rdData[17:0] = entry[idx];
      rdData[`LIS_DS_BIT] = pending[idx];
      if (idx == SRC_LOCAL0 || idx == SRC_LOCAL0 + 1) begin
         rdData[`LIS_RIR_BIT] = remotePend[idx - SRC_LOCAL0];
      end
   end else begin
      case (adr)
         `LIS_OFF_SPURIOUS: rdData[9:0] = {focusCheckDisable, softwareEnable, spuriousVector};
         `LIS_OFF_ERR_STATUS: rdData[7:0] = errStatus;
         `LIS_OFF_START_VALUE: rdData = startValue;
         `LIS_OFF_LIVE_VALUE: rdData = liveValue;
         `LIS_OFF_DIVIDER: rdData[3:0] = divCode;
         `LIS_OFF_EXT_FEATURE: rdData[`LIS_EXT_COUNT_LSB +: 8] = `LIS_EXT_COUNT;
         default: mapped = 1'b0;
      endcase
   end
end

always @* begin
   errNew = 8'h00;
   errNew[`LIS_ERR_SENT_UNACC] = sentUnaccepted;
   errNew[`LIS_ERR_RECV_UNACC] = receivedUnaccepted;
   errNew[`LIS_ERR_SENT_BADVEC] = pickBad;
   errNew[`LIS_ERR_RECV_BADVEC] = receivedBadVector;
   errNew[`LIS_ERR_BAD_ACCESS] = badAccess;
   rawEvt = {NSRC{1'b0}};
   rawEvt[SRC_TIMER] = timerFire;
   rawEvt[SRC_THERMAL] = thermalEvent;
   rawEvt[SRC_PERF] = perfOverflow;
   rawEvt[SRC_ERROR] = |errNew;
   for (i = 0; i < 2; i = i + 1) begin
      // Level handling only for fixed type; other types always edge.
      if (entry[SRC_LOCAL0+i][10:8] == `LIS_MT_FIXED && entry[SRC_LOCAL0+i][`LIS_TGM_BIT]) begin
         rawEvt[SRC_LOCAL0+i] = localInput[i] & ~remotePend[i];
      end else begin
         rawEvt[SRC_LOCAL0+i] = localInput[i] & ~localPrev[i];
      end
   end
   for (i = 0; i < 4; i = i + 1) begin
      if (extSource[i]) begin
         rawEvt[SRC_EXT0 + extSelect[2*i +: 2]] = 1'b1;
      end
   end
end

// Fixed priority by source index keeps the arbiter small; the lowest index wins.
always @* begin
   found = 1'b0;
   pick = 4'h0;
   pickType = 3'b000;
   for (j = 0; j < NSRC; j = j + 1) begin
      eligible[j] = pending[j] & (softwareEnable | (j == SRC_LOCAL0) | (j == SRC_LOCAL0 + 1) |
         ~gatedType(entry[j][10:8]));
   end
   // A level input awaiting end-of-interrupt stays pending but is not offered again.
   eligible[SRC_LOCAL0] = eligible[SRC_LOCAL0] & ~remotePend[0];
   eligible[SRC_LOCAL0+1] = eligible[SRC_LOCAL0+1] & ~remotePend[1];
   for (j = NSRC - 1; j >= 0; j = j - 1) begin
      if (eligible[j]) begin
         found = 1'b1;
         pick = j[3:0];
      end
   end
   pickType = entry[pick][10:8];
   next_pending = pending;
   if (pickBad) begin
      next_pending[pick] = 1'b0;
   end
   if (state == ST_OFFER && intAck) begin
      next_pending[chosen] = 1'b0;
   end
   for (j = 0; j < NSRC; j = j + 1) begin
      if (rawEvt[j] && !entry[j][`LIS_MASK_BIT]) begin
         next_pending[j] = 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      for (k = 0; k < NSRC; k = k + 1) begin
         entry[k] <= `LIS_ENTRY_RESET;
      end
      spuriousVector <= `LIS_SPURIOUS_RESET;
      softwareEnable <= 1'b0;
      focusCheckDisable <= 1'b0;
      startValue <= 32'h00000000;
      liveValue <= 32'h00000000;
      divCode <= 4'h0;
      timerRun <= 1'b0;
      divCnt <= 7'h00;
      errAccum <= 8'h00;
      errStatus <= 8'h00;
   end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? rdData : 32'h00000000;
      divCnt <= divCnt + 7'h01;
      if (timerFire) begin
         liveValue <= entry[SRC_TIMER][`LIS_TMM_BIT] ? startValue : 32'h00000000;
         timerRun <= entry[SRC_TIMER][`LIS_TMM_BIT];
      end else if (timerRun && tick) begin
         liveValue <= liveValue - 32'h00000001;
      end
      // A fresh error in the clearing cycle lands in the new accumulation.
      if (wr && adr == `LIS_OFF_ERR_STATUS) begin
         errStatus <= errAccum;
         errAccum <= errNew;
      end else begin
         errAccum <= errAccum | errNew;
      end
      if (wr) begin
         if (idx != 4'hf) begin
            entry[idx][10:0] <= wdat[10:0];
            entry[idx][`LIS_MASK_BIT] <= wdat[`LIS_MASK_BIT] | ~softwareEnable;
            if (idx == SRC_LOCAL0 || idx == SRC_LOCAL0 + 1) begin
               entry[idx][`LIS_TGM_BIT] <= wdat[`LIS_TGM_BIT];
            end
            if (idx == SRC_TIMER) begin
               entry[idx][`LIS_TMM_BIT] <= wdat[`LIS_TMM_BIT];
            end
         end
         case (adr)
            `LIS_OFF_SPURIOUS: begin
               spuriousVector <= wdat[7:0];
               softwareEnable <= wdat[`LIS_ENABLE_BIT];
               focusCheckDisable <= wdat[`LIS_FOCUS_BIT];
            end
            `LIS_OFF_START_VALUE: begin
               startValue <= wdat;
               liveValue <= wdat;
               timerRun <= (wdat != 32'h00000000);
               divCnt <= 7'h00;
            end
            `LIS_OFF_DIVIDER: divCode <= {wdat[3], 1'b0, wdat[1:0]};
            default: ;
         endcase
      end
      // Masks cannot be cleared while the block is disabled.
      if (!softwareEnable) begin
         for (k = 0; k < NSRC; k = k + 1) begin
            entry[k][`LIS_MASK_BIT] <= 1'b1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      pending <= {NSRC{1'b0}};
      remotePend <= 2'b00;
      localPrev <= 2'b00;
      state <= ST_IDLE;
      chosen <= 4'h0;
      intReq <= 1'b0;
      intVector <= 8'h00;
      intType <= 3'b000;
      ackValid <= 1'b0;
      ackVector <= 8'h00;
      ackSpurious <= 1'b0;
      inServiceSet <= 1'b0;
   end else begin
      pending <= next_pending;
      localPrev <= localInput;
      ackValid <= 1'b0;
      ackSpurious <= 1'b0;
      inServiceSet <= 1'b0;
      for (m = 0; m < 2; m = m + 1) begin
         if (state == ST_OFFER && intAck && chosen == SRC_LOCAL0 + m &&
            entry[SRC_LOCAL0+m][`LIS_TGM_BIT] && intType == `LIS_MT_FIXED) begin
            remotePend[m] <= 1'b1;
         end else if (endOfInterrupt[m]) begin
            remotePend[m] <= 1'b0;
         end
      end
      case (state)
         ST_IDLE: begin
            if (found && !pickBad) begin
               state <= ST_OFFER;
               chosen <= pick;
               intReq <= 1'b1;
               intType <= pickType;
               intVector <= (pickType == `LIS_MT_SMI) ? 8'h00 : entry[pick][7:0];
            end
         end
         ST_OFFER: begin
            if (intAck) begin
               state <= ST_IDLE;
               intReq <= 1'b0;
               ackValid <= 1'b1;
               // Spurious only for vectored types racing a priority raise.
               if (!intType[2] && !intType[1] && taskPriority[7:4] >= intVector[7:4]) begin
                  ackSpurious <= 1'b1;
                  ackVector <= spuriousVector;
               end else begin
                  ackVector <= intVector;
                  inServiceSet <= ~intType[2] & ~intType[1];
               end
            end
         end
         default: state <= ST_IDLE;
      endcase
   end
end

endmodule // lis_core

//--- shared/lis_regs.vh
`ifndef LIS_REGS_VH
`define LIS_REGS_VH
`define LIS_OFF_SPURIOUS 12'h0f0
`define LIS_OFF_ERR_STATUS 12'h280
`define LIS_OFF_TIMER_ENTRY 12'h320
`define LIS_OFF_THERMAL_ENTRY 12'h330
`define LIS_OFF_PERF_ENTRY 12'h340
`define LIS_OFF_LOCAL0_ENTRY 12'h350
`define LIS_OFF_LOCAL1_ENTRY 12'h360
`define LIS_OFF_ERROR_ENTRY 12'h370
`define LIS_OFF_START_VALUE 12'h380
`define LIS_OFF_LIVE_VALUE 12'h390
`define LIS_OFF_DIVIDER 12'h3e0
`define LIS_OFF_EXT_FEATURE 12'h400
`define LIS_OFF_EXT0_ENTRY 12'h500
`define LIS_OFF_EXT1_ENTRY 12'h510
`define LIS_OFF_EXT2_ENTRY 12'h520
`define LIS_OFF_EXT3_ENTRY 12'h530
`define LIS_ENTRY_RESET 18'h10000
`define LIS_SPURIOUS_RESET 8'hff
`define LIS_EXT_COUNT 8'h04
`define LIS_EXT_COUNT_LSB 16
`define LIS_MT_LSB 8
`define LIS_DS_BIT 12
`define LIS_RIR_BIT 14
`define LIS_TGM_BIT 15
`define LIS_MASK_BIT 16
`define LIS_TMM_BIT 17
`define LIS_ENABLE_BIT 8
`define LIS_FOCUS_BIT 9
`define LIS_ERR_SENT_UNACC 2
`define LIS_ERR_RECV_UNACC 3
`define LIS_ERR_SENT_BADVEC 5
`define LIS_ERR_RECV_BADVEC 6
`define LIS_ERR_BAD_ACCESS 7
`define LIS_MT_FIXED 3'b000
`define LIS_MT_LOWEST 3'b001
`define LIS_MT_SMI 3'b010
`define LIS_MT_NMI 3'b100
`define LIS_MT_EXTERNAL_INTERRUPT 3'b111
`define LIS_VEC_MIN 8'h10
`endif

//--- tb/lis_cpu_model.sv
module lis_cpu_model (
   input wire core_clk,
   input wire reset,
   input wire intReq,
   input wire [3:0] ackDelay,
   output reg intAck
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [3:0] waited;
   // The core takes one offer at a time and never acknowledges an absent one.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         intAck <= 1'b0;
         waited <= 4'h0;
      end else if (intAck || !intReq) begin
         intAck <= 1'b0;
         waited <= 4'h0;
      end else if (waited >= ackDelay) begin
         intAck <= 1'b1;
      end else begin
         waited <= waited + 4'h1;
      end
   end
endmodule // lis_cpu_model

//--- tb/lis_props.sv
`include "lis_regs.vh"
module lis_props (
   input wire core_clk,
   input wire reset,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire intReq,
   input wire [7:0] intVector,
   input wire [2:0] intType,
   input wire intAck,
   input wire ackValid,
   input wire ackSpurious,
   input wire inServiceSet,
   input wire softwareEnable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus answer late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer too long");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside answer");
   a_offer_holds: assert property (intReq && !intAck |=> intReq && $stable(intVector)
      && $stable(intType)) else $error("offer dropped or changed");
   a_ack_answer: assert property (intReq && intAck |=> ackValid && !intReq)
      else $error("acknowledge not answered");
   a_ack_cause: assert property (ackValid |-> $past(intReq) && $past(intAck))
      else $error("stray acknowledge answer");
   a_spurious_clean: assert property (ackSpurious |-> ackValid && !inServiceSet)
      else $error("spurious delivery touched service state");
   a_smi_vector: assert property (intReq && intType == `LIS_MT_SMI |-> intVector == 8'h00)
      else $error("management offer with vector");
   a_enable_cause: assert property ($changed(softwareEnable) |-> $past(wb_stb_i)
      && $past(wb_we_i) && !$past(wb_ack_o) && $past(wb_adr_i) == 12'h0f0)
      else $error("enable changed without write");
endmodule // lis_props
bind lis_core lis_props u_props (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .intReq(intReq), .intVector(intVector), .intType(intType),
   .intAck(intAck), .ackValid(ackValid), .ackSpurious(ackSpurious),
   .inServiceSet(inServiceSet), .softwareEnable(softwareEnable));

//--- tb/test_local_interrupt_sources.sv
module test_local_interrupt_sources;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
   logic [11:0] wbAdr = 12'h0;
   logic [31:0] wbDat = 32'h0, wbDatO;
   logic [1:0] localInput = 2'h0, endOfInterrupt = 2'h0;
   logic perfOverflow = 1'b0, thermalEvent = 1'b0, sentUnaccepted = 1'b0;
   logic receivedUnaccepted = 1'b0, receivedBadVector = 1'b0;
   logic [3:0] extSource = 4'h0, ackDelay = 4'h0;
   logic [7:0] extSelect = 8'h02, taskPriority = 8'h00, intVector, ackVector, lastVec, lastAckVec;
   logic [2:0] intType, lastType;
   logic intReq, intAck, ackValid, ackSpurious, inServiceSet, lastSpur, lastIs;
   logic softwareEnable, focusCheckDisable;
   int cyc = 0, nAcks = 0, ackCyc = 0, prevCyc = 0, n_fail = 0, cmp_count = 0, base;
   localparam logic [43:0] ROWS [17] = '{44'h0f0000000ff, 44'h28000000000, 44'h32000010000,
      44'h33000010000, 44'h34000010000, 44'h35000010000, 44'h36000010000, 44'h37000010000,
      44'h38000000000, 44'h39000000000, 44'h3e000000000, 44'h40000040000, 44'h50000010000,
      44'h51000010000, 44'h52000010000, 44'h53000010000, 44'h01000000000};
   lis_core dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .localInput(localInput), .endOfInterrupt(endOfInterrupt),
      .perfOverflow(perfOverflow), .thermalEvent(thermalEvent), .extSource(extSource),
      .extSelect(extSelect), .sentUnaccepted(sentUnaccepted),
      .receivedUnaccepted(receivedUnaccepted), .receivedBadVector(receivedBadVector),
      .taskPriority(taskPriority), .intReq(intReq), .intVector(intVector), .intType(intType),
      .intAck(intAck), .ackValid(ackValid), .ackVector(ackVector), .ackSpurious(ackSpurious),
      .inServiceSet(inServiceSet), .focusCheckDisable(focusCheckDisable),
      .softwareEnable(softwareEnable));
   lis_cpu_model cpu (.core_clk(core_clk), .reset(reset), .intReq(intReq),
      .ackDelay(ackDelay), .intAck(intAck));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   // Offers are captured at the acknowledge edge, results at the answer pulse.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (intReq && intAck) begin
         lastVec <= intVector;
         lastType <= intType;
      end
      if (ackValid) begin
         nAcks <= nAcks + 1;
         prevCyc <= ackCyc;
         ackCyc <= cyc;
         lastAckVec <= ackVector;
         lastSpur <= ackSpurious;
         lastIs <= inServiceSet;
      end
      if (cyc == 60000) begin
         n_fail++;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      wbAdr <= a;
      wbWe <= w;
      wbDat <= d;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      @(posedge core_clk);
      while (wbAck !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      chk(wbAck, 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(a, 1'b0, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic waitAcks(input int target);
      int n;
      n = 0;
      while (nAcks < target && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      chk(nAcks, target);
   endtask
   task automatic srcCase(input logic [11:0] a, input logic [31:0] e, input logic [2:0] p,
      input logic [7:0] vm, input logic [7:0] v);
      int b;
      wr(a, e);
      b = nAcks;
      {extSource[0], thermalEvent, perfOverflow} <= p;
      @(posedge core_clk);
      {extSource[0], thermalEvent, perfOverflow} <= 3'b000;
      waitAcks(b + 1);
      chk({lastType, lastVec & vm}, {e[10:8], v});
      idle(20);
      chk(nAcks, b + 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 17; i++) rd(ROWS[i][43:32], ROWS[i][31:0]);
      wr(12'h0f0, 32'h3ff);
      chk({focusCheckDisable, softwareEnable}, 2'h3);
      wr(12'h280, 32'h0);
      rd(12'h280, 32'h80);
      wr(12'h280, 32'h0);
      rd(12'h280, 32'h0);
      wr(12'h370, 32'h70);
      srcCase(12'h340, 32'h40, 3'b001, 8'hff, 8'h40);
      chk({lastSpur, lastIs, lastAckVec}, {1'b0, 1'b1, 8'h40});
      srcCase(12'h330, 32'h230, 3'b010, 8'hff, 8'h00);
      srcCase(12'h330, 32'h430, 3'b010, 8'h00, 8'h00);
      srcCase(12'h520, 32'h90, 3'b100, 8'hff, 8'h90);
      srcCase(12'h340, 32'h700, 3'b001, 8'h00, 8'h00);
      srcCase(12'h340, 32'h140, 3'b001, 8'hff, 8'h40);
      chk({lastSpur, lastIs, lastAckVec}, {1'b0, 1'b1, 8'h40});
      wr(12'h340, 32'h10040);
      base = nAcks;
      perfOverflow <= 1'b1;
      @(posedge core_clk);
      perfOverflow <= 1'b0;
      idle(20);
      chk(nAcks, base);
      ackDelay <= 4'h6;
      taskPriority <= 8'hf0;
      srcCase(12'h340, 32'h40, 3'b001, 8'hff, 8'h40);
      chk({lastSpur, lastIs, lastAckVec}, {1'b1, 1'b0, 8'hff});
      taskPriority <= 8'h00;
      base = nAcks;
      {sentUnaccepted, receivedUnaccepted, receivedBadVector} <= 3'b111;
      @(posedge core_clk);
      {sentUnaccepted, receivedUnaccepted, receivedBadVector} <= 3'b000;
      waitAcks(base + 1);
      chk(lastVec, 8'h70);
      idle(20);
      chk(nAcks, base + 1);
      wr(12'h280, 32'h0);
      rd(12'h280, 32'h4c);
      srcCase(12'h340, 32'h05, 3'b001, 8'hff, 8'h70);
      wr(12'h280, 32'h0);
      rd(12'h280, 32'h20);
      wr(12'h350, 32'h8060);
      base = nAcks;
      localInput[0] <= 1'b1;
      waitAcks(base + 1);
      idle(30);
      chk(nAcks, base + 1);
      endOfInterrupt[0] <= 1'b1;
      @(posedge core_clk);
      endOfInterrupt[0] <= 1'b0;
      waitAcks(base + 2);
      localInput[0] <= 1'b0;
      wr(12'h360, 32'h61);
      base = nAcks;
      localInput[1] <= 1'b1;
      waitAcks(base + 1);
      chk(lastVec, 8'h61);
      idle(30);
      chk(nAcks, base + 1);
      localInput[1] <= 1'b0;
      wr(12'h3e0, 32'hb);
      wr(12'h320, 32'h50);
      base = nAcks;
      wr(12'h380, 32'h5);
      waitAcks(base + 1);
      chk(lastVec, 8'h50);
      idle(40);
      chk(nAcks, base + 1);
      rd(12'h390, 32'h0);
      wr(12'h3e0, 32'ha);
      wr(12'h380, 32'h20);
      rd(12'h390, 32'h20);
      wr(12'h380, 32'h0);
      rd(12'h390, 32'h0);
      // A zero acknowledge delay keeps the answer latency fixed, so gaps equal periods.
      ackDelay <= 4'h0;
      wr(12'h320, 32'h20050);
      for (int i = 0; i < 8; i++) begin
         wr(12'h3e0, {28'h0, i[2], 1'b0, i[1:0]});
         base = nAcks;
         wr(12'h380, 32'h4);
         waitAcks(base + 3);
         chk(ackCyc - prevCyc, (i == 7) ? 4 : (4 << (i + 1)));
      end
      wr(12'h380, 32'h0);
      idle(10);
      base = nAcks;
      idle(600);
      chk(nAcks, base);
      wr(12'h0f0, 32'hff);
      chk({focusCheckDisable, softwareEnable}, 2'h0);
      wr(12'h340, 32'h05);
      rd(12'h340, 32'h10005);
      reset <= 1'b1;
      idle(2);
      reset <= 1'b0;
      @(posedge core_clk);
      chk({intReq, ackValid, inServiceSet, softwareEnable, focusCheckDisable}, 5'h00);
      rd(12'h350, 32'h10000);
      test_done;
   end
endmodule // test_local_interrupt_sources
